// [bench/pcp_board_model.sv]
// Board model: pin levels seen by the block.
// Assumes an unpulled, undriven pin floats; it toggles each cycle.
module pcp_board_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_pu,
    input wire logic [7:0] i_pd,
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext,
    output logic [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic flt_ff;
    always_ff @(posedge i_clk or posedge i_rst) flt_ff <= i_rst ? 1'b0 : ~flt_ff;
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
        | (~i_oe & ~i_ext_en & (i_pu | (~i_pd & {8{flt_ff}})));
endmodule : pcp_board_model

// [bench/pcp_port_ctrl_monitor.sv]
// Checker on the top ports of the port C pad control block.
// Assumes one clock and a registered one-cycle bus answer.
module pcp_port_ctrl_monitor (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    input wire logic [7:0] O_PIN_OE,
    input wire logic [7:0] I_PER_OUT,
    input wire logic [7:0] I_PER_IN,
    input wire logic [7:0] I_ANALOG,
    input wire logic [7:0] O_PULL_UP,
    input wire logic [7:0] O_PULL_DOWN,
    input wire logic [7:0] O_SLEW,
    input wire logic [7:0] O_DRIVE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    property p_ack; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
    a_pulse: assert property (p_pulse) else $error("ack long");
    property p_dat; O_WB_ACK |-> O_WB_DAT[31:8] == 24'h00_0000; endproperty
    a_dat: assert property (p_dat) else $error("upper data");
    property p_oe; !$past(I_RST) && !$past(I_PER_IN[6]) |-> O_PIN_OE[6] && !O_PIN_OE[7]; endproperty
    a_oe: assert property (p_oe) else $error("fixed pin oe");
    property p_own; ((O_PULL_UP | O_PULL_DOWN) & (I_PER_OUT & ~I_PER_IN | I_ANALOG)) == 8'h00;
    endproperty
    a_own: assert property (p_own) else $error("pull on owned");
    property p_fix; !O_PULL_UP[6] && !O_PULL_DOWN[6] && !O_SLEW[7] && !O_DRIVE[7]; endproperty
    a_fix: assert property (p_fix) else $error("fixed pin pad");
    property p_excl; (O_PULL_UP & O_PULL_DOWN) == 8'h00; endproperty
    a_excl: assert property (p_excl) else $error("up and down");
    property p_pdmask; (O_PULL_DOWN & 8'h4F) == 8'h00; endproperty
    a_pdmask: assert property (p_pdmask) else $error("pulldown pin");
    c_pd: cover property (O_PULL_DOWN != 8'h00);
    c_own: cover property ((I_PER_OUT & O_SLEW) != 8'h00);
    c_rd: cover property (O_WB_ACK && O_WB_DAT[7:0] != 8'h00);
endmodule : pcp_port_ctrl_monitor

bind pcp_port_ctrl pcp_port_ctrl_monitor u_mon (.*);

// [bench/tb.sv]
// Testbench: Wishbone tasks and directed pad checks.
// Assumes the board model drives the pins.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pcp_pkg::*;
    logic clk, rst, cyc, stb, we, ack;
    logic [7:0] adr, per_out, analog, ext_en, ext, q, pin, pout, oe, pu, pd, slew, drv;
    logic [31:0] dat, rdat;
    logic [7:0] offs [3] = '{PCP_OFS_PULL, PCP_OFS_SLEW, PCP_OFS_DRIVE};
    int failures = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    pcp_port_ctrl u_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(dat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .I_PIN(pin), .O_PIN(pout), .O_PIN_OE(oe), .I_PER_OUT(per_out),
        .I_PER_IN(8'h00), .I_PER_DATA(8'h00), .I_ANALOG(analog), .O_PULL_UP(pu),
        .O_PULL_DOWN(pd), .O_SLEW(slew), .O_DRIVE(drv));
    pcp_board_model u_board (.i_clk(clk), .i_rst(rst), .i_oe(oe), .i_out(pout), .i_pu(pu),
        .i_pd(pd), .i_ext_en(ext_en), .i_ext(ext), .o_pin(pin));
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
        @(posedge clk);
        if (n >= 20) begin
            failures++;
            test_done();
        end
    endtask : bus
    initial begin
        {clk, rst, cyc, stb, we, adr, dat, per_out, analog} = {2'b01, 59'h0};
        {ext_en, ext} = {8'hB0, 8'h80};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 8'h00);
            `CHK("reset", 8'h00, q)
            bus(1'b1, offs[i], 8'hA5);
            bus(1'b0, offs[i], 8'h00);
            `CHK("rw", 8'hA5, q)
            bus(1'b1, offs[i], 8'hFF);
        end
        bus(1'b0, 8'h40, 8'h00);
        `CHK("unmapped", 8'h00, q)
        $display("test regs done");
        `CHK("pu in", 8'hBF, pu)
        `CHK("slew in", 8'h40, slew)
        `CHK("drv in", 8'h40, drv)
        bus(1'b1, PCP_OFS_DIR, 8'h8F);
        `CHK("pu dir", 8'hB0, pu)
        `CHK("oe", 8'h4F, oe)
        `CHK("slew out", 8'h4F, slew)
        `CHK("drv out", 8'h4F, drv)
        bus(1'b1, PCP_OFS_KEY_EN, 8'hFF);
        bus(1'b1, PCP_OFS_KEY_POL, 8'hFF);
        `CHK("pd key", 8'hB0, pd)
        `CHK("pu key", 8'h00, pu)
        bus(1'b1, PCP_OFS_KEY_POL, 8'h00);
        `CHK("pu pol", 8'hB0, pu)
        $display("test pull done");
        per_out <= 8'h10;
        analog <= 8'h20;
        repeat (2) @(posedge clk);
        `CHK("pu own", 8'h80, pu)
        `CHK("slew own", 8'h5F, slew)
        bus(1'b0, PCP_OFS_OWNER, 8'h00);
        `CHK("own view", 8'h5F, q)
        per_out <= 8'h00;
        analog <= 8'h00;
        $display("test owner done");
        bus(1'b1, PCP_OFS_DATA, 8'h43);
        `CHK("pin", 8'h43, pout & oe)
        bus(1'b0, PCP_OFS_DATA, 8'h00);
        `CHK("rd out", 8'hC3, q)
        bus(1'b1, PCP_OFS_DIR, 8'h00);
        repeat (3) @(posedge clk);
        bus(1'b0, PCP_OFS_DATA, 8'h00);
        `CHK("rd in", 8'hCF, q)
        $display("test data done");
        test_done();
    end
endmodule : tb

// [common/pcp_cfg_if.sv]
// Interface carrying the stored port settings from the register file to the pad logic.
// Assumes both ends run on the same system clock.
interface pcp_cfg_if;
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] slew;
    logic [7:0] drive;
    logic [7:0] key_en;
    logic [7:0] key_pol;
    modport regs (output data, dir, pull, slew, drive, key_en, key_pol);
    modport pads (input data, dir, pull, slew, drive, key_en, key_pol);
endinterface : pcp_cfg_if

// [common/pcp_pkg.sv]
// Package for the port C pad control block: register offsets, field layouts and resets.
// Assumes a 32-bit classic Wishbone bus with byte addressing and word-aligned registers.
package pcp_pkg;
    localparam int PCP_PINS = 8;
    localparam int PCP_AW = 8;
    localparam logic [7:0] PCP_OFS_DATA = 8'h00;
    localparam logic [7:0] PCP_OFS_DIR = 8'h04;
    localparam logic [7:0] PCP_OFS_PULL = 8'h08;
    localparam logic [7:0] PCP_OFS_SLEW = 8'h0C;
    localparam logic [7:0] PCP_OFS_DRIVE = 8'h10;
    localparam logic [7:0] PCP_OFS_KEY_EN = 8'h14;
    localparam logic [7:0] PCP_OFS_KEY_POL = 8'h18;
    localparam logic [7:0] PCP_OFS_OWNER = 8'h1C;
    localparam logic [7:0] PCP_RST_REG = 8'h00;
    localparam int PCP_IN_ONLY_BIT = 7;
    localparam int PCP_OUT_ONLY_BIT = 6;
    localparam logic [7:0] PCP_KEY_PULLDOWN_MASK = 8'hB0;
    localparam logic [7:0] PCP_DIR_USABLE_MASK = 8'h3F;
    typedef enum logic [1:0] {
        PCP_BUS_IDLE,
        PCP_BUS_ACK
    } pcp_bus_state_t;
endpackage : pcp_pkg

// [hw/pcp_pad_logic.sv]
// Combinational pad control for the eight port pins.
// Assumes peripheral and analog ownership come in already synchronous to the system clock.
module pcp_pad_logic
    import pcp_pkg::*;
(
    pcp_cfg_if.pads cfg,
    input wire logic [7:0] i_per_out,
    input wire logic [7:0] i_per_in,
    input wire logic [7:0] i_analog,
    output logic [7:0] o_out_en,
    output logic [7:0] o_pull_up,
    output logic [7:0] o_pull_down,
    output logic [7:0] o_slew,
    output logic [7:0] o_drive
);
    logic [7:0] dir_eff;
    logic [7:0] is_out;
    logic [7:0] pull_on;
    logic [7:0] want_down;

    always_comb begin
        dir_eff = cfg.dir & PCP_DIR_USABLE_MASK;
        dir_eff[PCP_OUT_ONLY_BIT] = 1'b1;
        is_out = (dir_eff | i_per_out) & ~i_per_in;
        is_out[PCP_IN_ONLY_BIT] = 1'b0;
        o_out_en = is_out;
        // Pull only on inputs that no analog function owns and whose direction bit is 0; pin 7 ignores its direction bit.
        pull_on = cfg.pull & ~is_out & ~i_analog & ~cfg.dir;
        pull_on[PCP_IN_ONLY_BIT] = cfg.pull[PCP_IN_ONLY_BIT] & ~i_analog[PCP_IN_ONLY_BIT];
        pull_on[PCP_OUT_ONLY_BIT] = 1'b0;
        want_down = cfg.key_en & cfg.key_pol & PCP_KEY_PULLDOWN_MASK;
        o_pull_up = pull_on & ~want_down;
        o_pull_down = pull_on & want_down;
        o_slew = cfg.slew & is_out;
        o_drive = cfg.drive & is_out;
    end
endmodule : pcp_pad_logic

// [hw/pcp_port_ctrl.sv]
// Top level of the port C pad control block with its Wishbone register file.
// Assumes a classic Wishbone master on I_CLK_SYS and pins arriving asynchronously.
// Overview of operation
// - Each pin has its own pull-enable bit; one enables the pull.
// - Pull forced off while the pin drives as output by port or peripheral.
// - Pull forced off whenever an analog function owns the pin.
// - Pull-enable acts only when the pin's direction bit is zero, except on pin 7.
// - Pins 4, 5, 7 with key enabled and rising key polarity get pulldown instead.
// - Each pin has a slew-enable bit turning slew limiting on.
// - Slew-enable has no effect on input pins.
// - Each pin has a drive-select bit; one means high drive.
// - Drive-select has no effect on input pins.
// - Data bit 7 always reads the live level of input-only pin 7.
// - Data bit 6 always reads the latch of output-only pin 6.
// - Direction bits of pins 7 and 6 have no effect.
// - Slew and drive bits of pin 7 have no effect.
// - Pull-enable bit of pin 6 has no effect.
// - Pull, slew, drive work independent of data; direction and peripheral ownership gate them.
// - On pins 0 to 5, direction one drives output and reads latch; zero reads the pin.
// - Key polarity zero picks pullup, one picks pulldown on key-enabled pins 4, 5, 7.
module pcp_port_ctrl (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [pcp_pkg::PCP_AW-1:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    input wire logic [7:0] I_PIN,
    output logic [7:0] O_PIN,
    output logic [7:0] O_PIN_OE,
    input wire logic [7:0] I_PER_OUT,
    input wire logic [7:0] I_PER_IN,
    input wire logic [7:0] I_PER_DATA,
    input wire logic [7:0] I_ANALOG,
    output logic [7:0] O_PULL_UP,
    output logic [7:0] O_PULL_DOWN,
    output logic [7:0] O_SLEW,
    output logic [7:0] O_DRIVE
);
    import pcp_pkg::*;

    pcp_cfg_if cfg ();

    logic [7:0] data_ff;
    logic [7:0] dir_ff;
    logic [7:0] pull_ff;
    logic [7:0] slew_ff;
    logic [7:0] drive_ff;
    logic [7:0] key_en_ff;
    logic [7:0] key_pol_ff;
    logic [7:0] pin_meta_ff;
    logic [7:0] pin_sync_ff;
    logic [7:0] out_en;
    logic [7:0] pin_out_ff;
    logic [7:0] oe_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0] data_view;
    logic ack_ff;
    logic wr_go;
    logic rd_go;
    pcp_bus_state_t state_ff;

    assign cfg.data = data_ff;
    assign cfg.dir = dir_ff;
    assign cfg.pull = pull_ff;
    assign cfg.slew = slew_ff;
    assign cfg.drive = drive_ff;
    assign cfg.key_en = key_en_ff;
    assign cfg.key_pol = key_pol_ff;

    // The answer comes one cycle after the request is seen, so a write lands once only.
    assign wr_go = I_WB_CYC && I_WB_STB && I_WB_WE && (state_ff == PCP_BUS_IDLE);
    assign rd_go = I_WB_CYC && I_WB_STB && !I_WB_WE && (state_ff == PCP_BUS_IDLE);
    assign O_WB_ACK = ack_ff;
    assign O_WB_DAT = rdata_ff;

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            pin_meta_ff <= 8'h00;
            pin_sync_ff <= 8'h00;
        end else begin
            pin_meta_ff <= I_PIN;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            state_ff <= PCP_BUS_IDLE;
            ack_ff <= 1'b0;
        end else begin
            case (state_ff)
                PCP_BUS_IDLE: begin
                    if (I_WB_CYC && I_WB_STB) begin
                        state_ff <= PCP_BUS_ACK;
                        ack_ff <= 1'b1;
                    end
                end
                PCP_BUS_ACK: begin
                    state_ff <= PCP_BUS_IDLE;
                    ack_ff <= 1'b0;
                end
                default: begin
                    state_ff <= PCP_BUS_IDLE;
                    ack_ff <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            data_ff <= PCP_RST_REG;
            dir_ff <= PCP_RST_REG;
            pull_ff <= PCP_RST_REG;
            slew_ff <= PCP_RST_REG;
            drive_ff <= PCP_RST_REG;
            key_en_ff <= PCP_RST_REG;
            key_pol_ff <= PCP_RST_REG;
        end else if (wr_go && I_WB_SEL[0]) begin
            if (I_WB_ADR == PCP_OFS_DATA) begin
                data_ff <= I_WB_DAT[7:0];
            end else if (I_WB_ADR == PCP_OFS_DIR) begin
                dir_ff <= I_WB_DAT[7:0];
            end else if (I_WB_ADR == PCP_OFS_PULL) begin
                pull_ff <= I_WB_DAT[7:0];
            end else if (I_WB_ADR == PCP_OFS_SLEW) begin
                slew_ff <= I_WB_DAT[7:0];
            end else if (I_WB_ADR == PCP_OFS_DRIVE) begin
                drive_ff <= I_WB_DAT[7:0];
            end else if (I_WB_ADR == PCP_OFS_KEY_EN) begin
                key_en_ff <= I_WB_DAT[7:0];
            end else if (I_WB_ADR == PCP_OFS_KEY_POL) begin
                key_pol_ff <= I_WB_DAT[7:0];
            end
        end
    end

    pcp_pad_logic u_pad (
        .cfg(cfg.pads),
        .i_per_out(I_PER_OUT),
        .i_per_in(I_PER_IN),
        .i_analog(I_ANALOG),
        .o_out_en(out_en),
        .o_pull_up(O_PULL_UP),
        .o_pull_down(O_PULL_DOWN),
        .o_slew(O_SLEW),
        .o_drive(O_DRIVE)
    );

    // Peripheral-owned outputs take the peripheral's value; others take the latch.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            pin_out_ff <= 8'h00;
            oe_ff <= 8'h00;
        end else begin
            pin_out_ff <= (I_PER_OUT & I_PER_DATA) | (~I_PER_OUT & data_ff);
            oe_ff <= out_en;
        end
    end
    assign O_PIN = pin_out_ff;
    assign O_PIN_OE = oe_ff;

    always_comb begin
        data_view = (dir_ff & data_ff) | (~dir_ff & pin_sync_ff);
        data_view[PCP_IN_ONLY_BIT] = pin_sync_ff[PCP_IN_ONLY_BIT];
        data_view[PCP_OUT_ONLY_BIT] = data_ff[PCP_OUT_ONLY_BIT];
        nxt_rdata = 32'h0000_0000;
        if (I_WB_ADR == PCP_OFS_DATA) begin
            nxt_rdata[7:0] = data_view;
        end else if (I_WB_ADR == PCP_OFS_DIR) begin
            nxt_rdata[7:0] = dir_ff;
        end else if (I_WB_ADR == PCP_OFS_PULL) begin
            nxt_rdata[7:0] = pull_ff;
        end else if (I_WB_ADR == PCP_OFS_SLEW) begin
            nxt_rdata[7:0] = slew_ff;
        end else if (I_WB_ADR == PCP_OFS_DRIVE) begin
            nxt_rdata[7:0] = drive_ff;
        end else if (I_WB_ADR == PCP_OFS_KEY_EN) begin
            nxt_rdata[7:0] = key_en_ff;
        end else if (I_WB_ADR == PCP_OFS_KEY_POL) begin
            nxt_rdata[7:0] = key_pol_ff;
        end else if (I_WB_ADR == PCP_OFS_OWNER) begin
            nxt_rdata[7:0] = out_en;
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_go) begin
            rdata_ff <= nxt_rdata;
        end
    end
endmodule : pcp_port_ctrl
